// ---- pkg/wwd_pkg.sv ----
package wwd_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int unsigned WWD_CNT_W = 16;
   localparam int unsigned WWD_ADDR_W = 8;
   localparam int unsigned WWD_DATA_W = 32;
   localparam int unsigned WWD_PRESC_W = 14;
   localparam int unsigned WWD_EVT_W = 2;

   // ***************************************************************
   // register offsets (byte addresses)
   // ***************************************************************
   localparam logic [7:0] WWD_OFS_CTRL = 8'h00;
   localparam logic [7:0] WWD_OFS_RELOAD = 8'h04;
   localparam logic [7:0] WWD_OFS_WINDOW = 8'h08;
   localparam logic [7:0] WWD_OFS_COUNT = 8'h0c;
   localparam logic [7:0] WWD_OFS_STATUS = 8'h10;
   localparam logic [7:0] WWD_OFS_MASK = 8'h14;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int unsigned WWD_CTRL_SRC_BIT = 0;
   localparam int unsigned WWD_CTRL_DIV_BIT = 1;
   localparam int unsigned WWD_CTRL_RUN_BIT = 2;
   localparam int unsigned WWD_EVT_OVF_BIT = 0;
   localparam int unsigned WWD_EVT_WIN_BIT = 1;

   // ***************************************************************
   // reset values and counts
   // ***************************************************************
   // 256 ticks of 512 us on a 500 kHz wake-up clock: about 0.13 s
   localparam logic [15:0] WWD_RELOAD_RST = 16'hff00;
   localparam logic [15:0] WWD_WINDOW_RST = 16'hff00;
   localparam logic WWD_SRC_RST = 1'b1;
   localparam logic WWD_DIV_RST = 1'b0;
   localparam logic [1:0] WWD_MASK_RST = 2'h0;
   localparam int unsigned WWD_DIV_LO = 256;
   localparam int unsigned WWD_DIV_HI = 16384;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      WWD_ST_RUN = 2'b01,
      WWD_ST_STOP = 2'b10
   } wwd_state_t;

   typedef enum logic {
      WWD_SRC_SYS = 1'b0,
      WWD_SRC_WU = 1'b1
   } wwd_src_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } wwd_bus_req_t;

   typedef struct packed {
      logic dis;
      logic en;
      logic srv;
   } wwd_instr_t;

   typedef struct packed {
      wwd_src_t src;
      logic div_hi;
   } wwd_cfg_t;

endpackage

// ---- logic/wwd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module wwd_sync (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // pin side
   input wire logic async_i,
   // filtered result
   output logic level_o,
   output logic rise_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         rise_q <= (s2_q == s3_q) && s2_q && !level_q;
         if (s2_q == s3_q) begin
            level_q <= s2_q;
         end
      end
   end

   assign level_o = level_q;
   assign rise_o = rise_q;
endmodule
`default_nettype wire

// ---- logic/wwd_presc.sv ----
`timescale 1ns/1ps
`default_nettype none
module wwd_presc #(
   parameter int unsigned PW = 14,
   parameter int unsigned DIV_LO = 256,
   parameter int unsigned DIV_HI = 16384
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // control
   input wire logic in_tick_i,
   input wire logic clr_i,
   input wire logic div_hi_i,
   // output tick
   output logic tick_o
);
   logic [PW-1:0] cnt_q;
   logic [PW-1:0] lim;
   logic tick_q;

   assign lim = div_hi_i ? PW'(DIV_HI - 1) : PW'(DIV_LO - 1);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (clr_i) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (in_tick_i && (cnt_q >= lim)) begin
         cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= in_tick_i ? cnt_q + PW'(1) : cnt_q;
         tick_q <= 1'b0;
      end
   end

   assign tick_o = tick_q;
endmodule
`default_nettype wire

// ---- logic/wwd_top.sv ----
// Summary of operation
// - after reset the watchdog runs at once, no software start needed
// - disable instruction stops it unless enable comes in the same cycle, enable instruction restarts it at any time
// - counter overflow from missing service raises a reset request
// - service inside the forbidden window raises a reset request, no reload
// - counter is 16 bits wide and counts up
// - source is system or wake-up clock, prescaled by 16384 or 256
// - each valid service loads the counter from the reload register
// - power-up defaults give about 0.13 s on a 500 kHz wake-up clock
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // register port
   input wire wwd_pkg::wwd_bus_req_t bus_req_i,
   output logic [31:0] rdata_o,
   // cpu instructions, one-cycle pulses
   input wire wwd_pkg::wwd_instr_t instr_i,
   // wake-up oscillator pin
   input wire logic wakeup_oscillator_clock_i,
   // reset controller
   input wire logic reset_ack_i,
   output logic reset_req_o,
   // interrupt
   output logic irq_o
);
   import wwd_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   wwd_state_t st_q;
   wwd_cfg_t cfg_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] watchdog_reload_value_q;
   logic [15:0] win_q;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic [1:0] evt;
   logic [1:0] w1c;
   logic [31:0] rdata_q;
   logic irq_q;
   logic rst_req_q;
   logic running;
   logic wu_rise;
   logic presc_in;
   logic presc_tick;
   logic presc_clr;
   logic cfg_wr;
   logic srv_ok;
   logic win_viol;
   logic ovf;

   // ***************************************************************
   // wake-up clock and prescaler
   // ***************************************************************
   wwd_sync u_wu_sync (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .async_i(wakeup_oscillator_clock_i),
      .level_o(),
      .rise_o(wu_rise)
   );

   assign presc_in = (cfg_q.src == WWD_SRC_WU) ? wu_rise : 1'b1;
   assign cfg_wr = bus_req_i.wr && (bus_req_i.addr == WWD_OFS_CTRL);
   // restart the prescaler so every interval starts from a full tick
   assign presc_clr = srv_ok || ovf || cfg_wr;

   wwd_presc #(
      .PW(WWD_PRESC_W),
      .DIV_LO(WWD_DIV_LO),
      .DIV_HI(WWD_DIV_HI)
   ) u_presc (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .in_tick_i(presc_in),
      .clr_i(presc_clr),
      .div_hi_i(cfg_q.div_hi),
      .tick_o(presc_tick)
   );

   // ***************************************************************
   // run / stop
   // ***************************************************************
   assign running = (st_q == WWD_ST_RUN);

   // enable wins when both arrive together: fail safe
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= WWD_ST_RUN;
      end else begin
         case (st_q)
            WWD_ST_RUN: begin
               if (instr_i.dis && !instr_i.en) begin
                  st_q <= WWD_ST_STOP;
               end
            end
            WWD_ST_STOP: begin
               if (instr_i.en) begin
                  st_q <= WWD_ST_RUN;
               end
            end
            default: begin
               st_q <= WWD_ST_RUN;
            end
         endcase
      end
   end

   // ***************************************************************
   // counter, window and overflow
   // ***************************************************************
   // a stopped watchdog reloads on service without a window check
   assign win_viol = instr_i.srv && running && (cnt_q < win_q);
   assign srv_ok = instr_i.srv && !win_viol;
   assign ovf = running && presc_tick && (cnt_q == 16'hffff) && !srv_ok;

   always_comb begin
      cnt_d = cnt_q;
      if (srv_ok) begin
         cnt_d = watchdog_reload_value_q;
      end else if (ovf) begin
         cnt_d = watchdog_reload_value_q;
      end else if (running && presc_tick) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= WWD_RELOAD_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // set wins over acknowledge
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_req_q <= 1'b0;
      end else if (ovf || win_viol) begin
         rst_req_q <= 1'b1;
      end else if (reset_ack_i) begin
         rst_req_q <= 1'b0;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q.src <= wwd_src_t'(WWD_SRC_RST);
         cfg_q.div_hi <= WWD_DIV_RST;
      end else if (cfg_wr) begin
         cfg_q.src <= wwd_src_t'(bus_req_i.wdata[WWD_CTRL_SRC_BIT]);
         cfg_q.div_hi <= bus_req_i.wdata[WWD_CTRL_DIV_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         watchdog_reload_value_q <= WWD_RELOAD_RST;
      end else if (bus_req_i.wr && (bus_req_i.addr == WWD_OFS_RELOAD)) begin
         watchdog_reload_value_q <= bus_req_i.wdata[15:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         win_q <= WWD_WINDOW_RST;
      end else if (bus_req_i.wr && (bus_req_i.addr == WWD_OFS_WINDOW)) begin
         win_q <= bus_req_i.wdata[15:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_q <= WWD_MASK_RST;
      end else if (bus_req_i.wr && (bus_req_i.addr == WWD_OFS_MASK)) begin
         mask_q <= bus_req_i.wdata[1:0];
      end
   end

   // ***************************************************************
   // sticky status and interrupt
   // ***************************************************************
   always_comb begin
      evt = '0;
      evt[WWD_EVT_OVF_BIT] = ovf;
      evt[WWD_EVT_WIN_BIT] = win_viol;
      w1c = '0;
      if (bus_req_i.wr && (bus_req_i.addr == WWD_OFS_STATUS)) begin
         w1c = bus_req_i.wdata[1:0];
      end
      stat_d = (stat_q & ~w1c) | evt;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= '0;
         if (bus_req_i.rd) begin
            if (bus_req_i.addr == WWD_OFS_CTRL) begin
               rdata_q[WWD_CTRL_SRC_BIT] <= cfg_q.src;
               rdata_q[WWD_CTRL_DIV_BIT] <= cfg_q.div_hi;
               rdata_q[WWD_CTRL_RUN_BIT] <= running;
            end else if (bus_req_i.addr == WWD_OFS_RELOAD) begin
               rdata_q[15:0] <= watchdog_reload_value_q;
            end else if (bus_req_i.addr == WWD_OFS_WINDOW) begin
               rdata_q[15:0] <= win_q;
            end else if (bus_req_i.addr == WWD_OFS_COUNT) begin
               rdata_q[15:0] <= cnt_q;
            end else if (bus_req_i.addr == WWD_OFS_STATUS) begin
               rdata_q[1:0] <= stat_q;
            end else if (bus_req_i.addr == WWD_OFS_MASK) begin
               rdata_q[1:0] <= mask_q;
            end
         end
      end
   end

   assign rdata_o = rdata_q;
   assign reset_req_o = rst_req_q;
   assign irq_o = irq_q;

   // ***************************************************************
   // checks
   // ***************************************************************
   logic seen_dis_q;
   logic seen_wr_q;
   int gap_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seen_dis_q <= 1'b0;
         seen_wr_q <= 1'b0;
         gap_q <= 0;
      end else begin
         seen_dis_q <= seen_dis_q || instr_i.dis;
         seen_wr_q <= seen_wr_q || bus_req_i.wr;
         gap_q <= presc_clr ? 0 : (presc_tick ? 1 : gap_q + 1);
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_run_after_reset;
      !seen_dis_q |-> running;
   endproperty
   a_run_after_reset: assert property (p_run_after_reset)
      else $error("watchdog not running after reset");

   property p_dis_en;
      (instr_i.dis && !instr_i.en |=> !running) and (instr_i.en |=> running);
   endproperty
   a_dis_en: assert property (p_dis_en)
      else $error("disable or enable instruction not obeyed");

   property p_ovf_req;
      running && presc_tick && cnt_q == 16'hffff && !instr_i.srv
         |=> reset_req_o && cnt_q == $past(watchdog_reload_value_q);
   endproperty
   a_ovf_req: assert property (p_ovf_req)
      else $error("overflow gave no reset request");

   property p_win_viol;
      instr_i.srv && running && cnt_q < win_q
         |=> reset_req_o && stat_q[WWD_EVT_WIN_BIT];
   endproperty
   a_win_viol: assert property (p_win_viol)
      else $error("service in forbidden window not flagged");

   property p_count_up;
      running && presc_tick && !instr_i.srv && cnt_q != 16'hffff
         |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("counter did not step up by one");

   property p_presc_gap;
      presc_tick && cfg_q.src == WWD_SRC_SYS
         |-> gap_q == (cfg_q.div_hi ? WWD_DIV_HI : WWD_DIV_LO);
   endproperty
   a_presc_gap: assert property (p_presc_gap)
      else $error("prescaler tick spacing wrong");

   property p_reload;
      srv_ok |=> cnt_q == $past(watchdog_reload_value_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("valid service did not reload");

   property p_defaults;
      !seen_wr_q |-> watchdog_reload_value_q == WWD_RELOAD_RST
         && cfg_q.src == WWD_SRC_WU && !cfg_q.div_hi;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("power-up defaults lost");

   property p_req_hold;
      reset_req_o && !reset_ack_i |=> reset_req_o;
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("reset request dropped without acknowledge");

   property p_win_open;
      instr_i.srv && running && cnt_q >= win_q && !reset_req_o |=> !reset_req_o;
   endproperty
   a_win_open: assert property (p_win_open)
      else $error("service after boundary raised reset request");

   c_ovf: cover property (ovf);
   c_win_viol: cover property (win_viol);
   c_srv_ok: cover property (srv_ok && running);
   c_stop: cover property (!running ##1 running);
endmodule
`default_nettype wire

// ---- sim/wwd_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wwd_far_model #(
   parameter int unsigned WU_HALF = 3
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // test control
   input wire logic ack_en_i,
   // watchdog side
   input wire logic reset_req_i,
   output logic reset_ack_o,
   output logic wakeup_oscillator_clock_o
);
   // ***************************************************************
   // wake-up oscillator
   // ***************************************************************
   // free running like the real oscillator, period 2*WU_HALF cycles
   logic [7:0] wu_cnt_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wu_cnt_q <= 8'h00;
         wakeup_oscillator_clock_o <= 1'b0;
      end else if (wu_cnt_q == 8'(WU_HALF - 1)) begin
         wu_cnt_q <= 8'h00;
         wakeup_oscillator_clock_o <= ~wakeup_oscillator_clock_o;
      end else begin
         wu_cnt_q <= wu_cnt_q + 8'h01;
      end
   end

   // ***************************************************************
   // reset controller
   // ***************************************************************
   // ack withheld until the bench allows it, so the hold can be seen
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reset_ack_o <= 1'b0;
      end else begin
         reset_ack_o <= ack_en_i & reset_req_i;
      end
   end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wwd_pkg::*;

   // ***************************************************************
   // signals and instances
   // ***************************************************************
   localparam logic [2:0] I_DIS = 3'b100;
   localparam logic [2:0] I_EN = 3'b010;
   localparam logic [2:0] I_SRV = 3'b001;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   wwd_bus_req_t bus_req = '0;
   wwd_instr_t instr = '0;
   logic [31:0] rdata;
   logic reset_req;
   logic reset_ack;
   logic irq;
   logic wu_clk;
   logic ack_en = 1'b0;
   int mismatches = 0;
   int n_compared = 0;
   logic [31:0] v;
   logic [31:0] cfg [3] = '{32'h0, 32'h2, 32'h1};
   int t_pre [3] = '{200, 16000, 1350};
   int t_post [3] = '{80, 600, 450};

   always #50 sys_clk = ~sys_clk;

   wwd_top i_wwd_top (
      .sys_clk_i(sys_clk),
      .arst_n_i(arst_n),
      .bus_req_i(bus_req),
      .rdata_o(rdata),
      .instr_i(instr),
      .wakeup_oscillator_clock_i(wu_clk),
      .reset_ack_i(reset_ack),
      .reset_req_o(reset_req),
      .irq_o(irq)
   );

   wwd_far_model #(.WU_HALF(3)) i_wwd_far_model (
      .sys_clk_i(sys_clk),
      .arst_n_i(arst_n),
      .ack_en_i(ack_en),
      .reset_req_i(reset_req),
      .reset_ack_o(reset_ack),
      .wakeup_oscillator_clock_o(wu_clk)
   );

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask

   task automatic do_instr(input logic [2:0] k);
      @(posedge sys_clk);
      instr <= k;
      @(posedge sys_clk);
      instr <= '0;
      @(negedge sys_clk);
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (3) @(posedge sys_clk);
      chk({30'h0, reset_req, irq}, 32'h0);
      arst_n <= 1'b1;
      // power-up state: running, wake-up source, divide 256
      bus_rd(WWD_OFS_CTRL, v); chk(v, 32'h5);
      bus_rd(WWD_OFS_RELOAD, v); chk(v, 32'hff00);
      bus_rd(WWD_OFS_WINDOW, v); chk(v, 32'hff00);
      bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hff00);
      bus_rd(WWD_OFS_STATUS, v); chk(v, 32'h0);
      bus_rd(WWD_OFS_MASK, v); chk(v, 32'h0);
      bus_wr(8'h18, 32'h1234);
      bus_rd(8'h18, v); chk(v, 32'h0);
      bus_rd(WWD_OFS_RELOAD, v); chk(v, 32'hff00);
      bus_wr(WWD_OFS_RELOAD, 32'hfff0);
      bus_wr(WWD_OFS_WINDOW, 32'hfff4);
      // early service while count below boundary
      do_instr(I_SRV);
      chk({31'h0, reset_req}, 32'h1);
      bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hff00);
      bus_rd(WWD_OFS_STATUS, v); chk(v, 32'h2);
      chk({31'h0, irq}, 32'h0);
      bus_wr(WWD_OFS_MASK, 32'h3);
      repeat (2) @(negedge sys_clk);
      chk({31'h0, irq}, 32'h1);
      bus_wr(WWD_OFS_STATUS, 32'h2);
      repeat (2) @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      repeat (20) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h1);
      ack_en <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h0);
      ack_en <= 1'b0;
      bus_wr(WWD_OFS_MASK, 32'h1);
      // stopped: service reloads without window check, no counting
      do_instr(I_DIS);
      do_instr(I_SRV);
      bus_wr(WWD_OFS_CTRL, 32'h0);
      repeat (300) @(posedge sys_clk);
      bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hfff0);
      bus_rd(WWD_OFS_CTRL, v); chk(v, 32'h0);
      chk({31'h0, reset_req}, 32'h0);
      do_instr(I_DIS | I_EN);
      bus_rd(WWD_OFS_CTRL, v); chk(v, 32'h4);
      // tick period for system clock at divide 256 and 16384, and wake-up clock at divide 256
      for (int k = 0; k < 3; k++) begin
         do_instr(I_DIS);
         do_instr(I_SRV);
         do_instr(I_EN);
         bus_wr(WWD_OFS_CTRL, cfg[k]);
         bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hfff0);
         repeat (t_pre[k]) @(posedge sys_clk);
         bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hfff0);
         repeat (t_post[k]) @(posedge sys_clk);
         bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hfff1);
      end
      // missed service: overflow after 16 ticks of 256 cycles
      do_instr(I_DIS);
      do_instr(I_SRV);
      do_instr(I_EN);
      bus_wr(WWD_OFS_CTRL, 32'h0);
      // request rises at the edge 4097 cycles after the control write
      repeat (4097) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h0);
      @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h1);
      bus_rd(WWD_OFS_STATUS, v); chk(v, 32'h1);
      chk({31'h0, irq}, 32'h1);
      repeat (20) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h1);
      ack_en <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h0);
      ack_en <= 1'b0;
      bus_wr(WWD_OFS_STATUS, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      // service exactly at the boundary is honoured
      v = 32'h0;
      for (int i = 0; i < 600 && v !== 32'hfff4; i++) bus_rd(WWD_OFS_COUNT, v);
      do_instr(I_SRV);
      repeat (2) @(negedge sys_clk);
      chk({31'h0, reset_req}, 32'h0);
      bus_rd(WWD_OFS_COUNT, v); chk(v, 32'hfff0);
      print_verdict();
   end
endmodule
`default_nettype wire
